// [rtl/pps_pkg.sv]
// Purpose: constants for the power sequencer
// Assumes: 20 MHz clock
// Notes:   times in microseconds, counts derived
package pps_pkg;
  localparam int unsigned CLK_MHZ         = 20;
  // ---------------------------------------------------------------------
  // sequencing times (us)
  // ---------------------------------------------------------------------
  localparam int unsigned LDO_SS_US       = 275;
  localparam int unsigned BUCK_SS_US      = 600;
  localparam int unsigned BUCK_START_US   = 500;
  localparam int unsigned LDO2_OFF_US     = 1500;
  localparam int unsigned LDO1_OFF_US     = 2000;
  localparam int unsigned BUCK2_OFF_US    = 1000;
  localparam int unsigned BUCK1_OFF_US    = 500;
  localparam int unsigned RST_REL_US      = 20000;
  localparam int unsigned EXTERNAL_SUPPLY_ENABLE_OUT_US       = 2500;
  localparam int unsigned LDO_SS_CYC      = LDO_SS_US * CLK_MHZ;
  localparam int unsigned BUCK_SS_CYC     = BUCK_SS_US * CLK_MHZ;
  localparam int unsigned BUCK_START_CYC  = BUCK_START_US * CLK_MHZ;
  localparam int unsigned LDO2_OFF_CYC    = LDO2_OFF_US * CLK_MHZ;
  localparam int unsigned LDO1_OFF_CYC    = LDO1_OFF_US * CLK_MHZ;
  localparam int unsigned BUCK2_OFF_CYC   = BUCK2_OFF_US * CLK_MHZ;
  localparam int unsigned BUCK1_OFF_CYC   = BUCK1_OFF_US * CLK_MHZ;
  localparam int unsigned RST_REL_CYC     = RST_REL_US * CLK_MHZ;
  localparam int unsigned EXTERNAL_SUPPLY_ENABLE_OUT_CYC      = EXTERNAL_SUPPLY_ENABLE_OUT_US * CLK_MHZ;
  // ---------------------------------------------------------------------
  // i2c target address and voltage codes (0.8 V + 12.5 mV * code; buck2 codes from 0.6 V)
  // ---------------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR7        = 7'h25;
  localparam logic [7:0] I2C_WR_BYTE      = {I2C_ADDR7, 1'b0};
  localparam logic [7:0] I2C_RD_BYTE      = {I2C_ADDR7, 1'b1};
  localparam int unsigned VBASE_MV10      = 8000;
  localparam int unsigned VSTEP_MV10      = 125;
  // buck2 base is a chosen 0.6 V so that both of its levels can be coded
  localparam int unsigned B2_BASE_MV10    = 6000;
  localparam logic [7:0] CODE_0V75        = 8'h0C;
  localparam logic [7:0] CODE_0V9         = 8'h18;
  localparam logic [7:0] CODE_1V2         = 8'h20;
  localparam logic [7:0] CODE_1V8         = 8'h50;
  localparam logic [7:0] CODE_3V3         = 8'hC8;
  localparam logic [7:0] CODE_MAX         = 8'hFF;
  // ---------------------------------------------------------------------
  // sleep defaults
  // ---------------------------------------------------------------------
  localparam logic SLEEP_MODE_RST         = 1'b0;
  localparam logic SLEEP_EN_RST           = 1'b0;
  localparam logic SLEEP_REQ_RST          = 1'b0;
  localparam logic DEEP_MODE_RST          = 1'b1;
  localparam logic DEEP_EN_RST            = 1'b0;
  localparam logic DEEP_REQ_RST           = 1'b0;
  typedef enum logic [1:0] {PPS_OFF, PPS_START, PPS_SS, PPS_ON} pps_rail_e;
endpackage

// [rtl/pps_rail.sv]
// Purpose: one rail of the sequence: delay, soft-start, shutdown delay
// Assumes: trigger_i is a level from the previous rail's good, or uvlo release for ldo2
// Notes:   good_o rises when soft-start ends; off waits the shutdown delay
`timescale 1ns/10ps
`default_nettype none
module pps_rail
  import pps_pkg::*;
#(
  parameter int unsigned START_CYC = 1,
  parameter int unsigned SS_CYC    = 1,
  parameter int unsigned OFF_CYC   = 0
)(
  // clock
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  // sequence
  input  wire logic trigger_i,
  output logic      enable_o,
  output logic      good_o
);
  localparam int unsigned W = 20;
  pps_rail_e      state_reg;
  logic [W-1:0]   cnt_reg;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= PPS_OFF;
      cnt_reg   <= '0;
    end
    else if (ce_i)
    begin
      unique case (state_reg)
        PPS_OFF:
          if (trigger_i)
          begin
            state_reg <= PPS_START;
            cnt_reg   <= '0;
          end
        PPS_START:
          if (!trigger_i)
            state_reg <= PPS_OFF;
          else if (cnt_reg >= W'(START_CYC))
          begin
            state_reg <= PPS_SS;
            cnt_reg   <= '0;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        PPS_SS:
          if (cnt_reg >= W'(SS_CYC - 1))
          begin
            state_reg <= PPS_ON;
            cnt_reg   <= '0;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        PPS_ON:
          // shutdown delay counts from loss of the trigger
          if (trigger_i)
            cnt_reg <= '0;
          else if (cnt_reg >= W'(OFF_CYC))
            state_reg <= PPS_OFF;
          else
            cnt_reg <= cnt_reg + 1'b1;
      endcase
    end
  end

  assign enable_o = (state_reg == PPS_SS) || (state_reg == PPS_ON);
  assign good_o   = (state_reg == PPS_ON);
endmodule // pps_rail
`default_nettype wire

// [rtl/pps_sequencer.sv]
// Purpose: rail sequencing, reset release and mode select for one config
// Assumes: 20 MHz clock; pins arrive asynchronous
// Notes:   i2c transport lives elsewhere; only its address is matched here
`timescale 1ns/10ps
`default_nettype none
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int unsigned RST_CYC = RST_REL_CYC,
  parameter int unsigned EXT_CYC = EXTERNAL_SUPPLY_ENABLE_OUT_CYC
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // pins
  input  wire logic        input_undervoltage_lockout_i,
  input  wire logic        voltage_select_input_i,
  input  wire logic        level_select_input_i,
  input  wire logic [7:0]  addr_byte_i,
  output logic             addr_match_o,
  output logic             addr_read_o,
  // open-drain outputs
  output logic             system_reset_release_out_o,
  output logic             system_reset_release_out_oe_o,
  output logic             external_supply_enable_out_o,
  output logic             external_supply_enable_out_oe_o,
  // rail enables and good flags, order ldo2 ldo1 buck2 buck1 buck3
  output logic [4:0]       rail_enable_o,
  output logic [4:0]       rail_good_o,
  // voltage codes
  output logic [7:0]       buck1_code_o,
  output logic [7:0]       buck2_code_o,
  output logic [7:0]       buck3_code_o,
  output logic [7:0]       ldo_voltage_code_o,
  output logic [15:0]      buck2_mv10_o,
  output logic [15:0]      ldo_mv10_o,
  output logic             dvs_mode_o,
  // sleep controls
  output logic             sleep_mode_o,
  output logic             sleep_enable_o,
  output logic             sleep_request_o,
  output logic             deep_sleep_mode_select_o,
  output logic             deep_sleep_enable_ctl_o,
  output logic             deep_sleep_request_ctl_o
);
  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_reg <= 3'b111;
      sync2_reg <= 3'b111;
    end
    else if (ce_i)
    begin
      sync1_reg <= {input_undervoltage_lockout_i, voltage_select_input_i,
                    level_select_input_i};
      sync2_reg <= sync1_reg;
    end
  end
  logic uvlo_s, vsel_s, lsel_s;
  assign uvlo_s = sync2_reg[2];
  assign vsel_s = sync2_reg[1];
  assign lsel_s = sync2_reg[0];

  // -----------------------------------------------------------------------
  // rail chain
  // -----------------------------------------------------------------------
  logic [4:0] en_w, good_w;
  pps_rail #(.START_CYC(1), .SS_CYC(LDO_SS_CYC), .OFF_CYC(LDO2_OFF_CYC))
    u_ldo2 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
            .trigger_i(!uvlo_s), .enable_o(en_w[0]), .good_o(good_w[0]));
  pps_rail #(.START_CYC(1), .SS_CYC(LDO_SS_CYC), .OFF_CYC(LDO1_OFF_CYC))
    u_ldo1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
            .trigger_i(good_w[0]), .enable_o(en_w[1]), .good_o(good_w[1]));
  pps_rail #(.START_CYC(BUCK_START_CYC), .SS_CYC(BUCK_SS_CYC),
             .OFF_CYC(BUCK2_OFF_CYC))
    u_buck2 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
             .trigger_i(good_w[1]), .enable_o(en_w[2]), .good_o(good_w[2]));
  pps_rail #(.START_CYC(BUCK_START_CYC), .SS_CYC(BUCK_SS_CYC),
             .OFF_CYC(BUCK1_OFF_CYC))
    u_buck1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
             .trigger_i(good_w[2]), .enable_o(en_w[3]), .good_o(good_w[3]));
  pps_rail #(.START_CYC(BUCK_START_CYC), .SS_CYC(BUCK_SS_CYC), .OFF_CYC(0))
    u_buck3 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
             .trigger_i(good_w[3]), .enable_o(en_w[4]), .good_o(good_w[4]));
  assign rail_enable_o = en_w;
  assign rail_good_o   = good_w;

  // -----------------------------------------------------------------------
  // reset release and external enable delays
  // -----------------------------------------------------------------------
  logic [19:0] rst_cnt_reg;
  logic [19:0] ext_cnt_reg;
  logic        rst_rel_reg;
  logic        external_supply_enable_out_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rst_cnt_reg <= '0;
      rst_rel_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!good_w[4])
      begin
        rst_cnt_reg <= '0;
        rst_rel_reg <= 1'b0;
      end
      else if (rst_cnt_reg >= 20'(RST_CYC - 1))
        rst_rel_reg <= 1'b1;
      else
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ext_cnt_reg <= '0;
      external_supply_enable_out_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!good_w[2])
      begin
        ext_cnt_reg <= '0;
        external_supply_enable_out_reg  <= 1'b0;
      end
      else if (ext_cnt_reg >= 20'(EXT_CYC - 1))
        external_supply_enable_out_reg <= 1'b1;
      else
        ext_cnt_reg <= ext_cnt_reg + 1'b1;
    end
  end
  // open drain: drive low while not released
  assign system_reset_release_out_o      = 1'b0;
  assign system_reset_release_out_oe_o   = !rst_rel_reg;
  assign external_supply_enable_out_o    = 1'b0;
  assign external_supply_enable_out_oe_o = !external_supply_enable_out_reg;

  // -----------------------------------------------------------------------
  // address match and voltage codes
  // -----------------------------------------------------------------------
  assign addr_match_o = (addr_byte_i[7:1] == I2C_ADDR7);
  assign addr_read_o  = (addr_byte_i == I2C_RD_BYTE);

  // board strap is static, so plain registering is enough
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      buck1_code_o       <= CODE_3V3;
      buck2_code_o       <= CODE_0V9;
      buck3_code_o       <= CODE_1V2;
      ldo_voltage_code_o <= CODE_1V8;
      dvs_mode_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      buck3_code_o <= vsel_s ? CODE_1V2 : CODE_1V8;
      buck2_code_o <= lsel_s ? CODE_0V9 : CODE_0V75;
      dvs_mode_o   <= !lsel_s;
      buck1_code_o <= CODE_3V3;
      ldo_voltage_code_o <= CODE_1V8;
    end
  end
  function automatic logic [15:0] code_to_mv10(input logic [15:0] base,
                                               input logic [7:0]  c);
    code_to_mv10 = base + 16'(c) * 16'(VSTEP_MV10);
  endfunction
  assign buck2_mv10_o = code_to_mv10(16'(B2_BASE_MV10), buck2_code_o);
  assign ldo_mv10_o   = code_to_mv10(16'(VBASE_MV10),
                                     ldo_voltage_code_o);

  // -----------------------------------------------------------------------
  // sleep defaults
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sleep_mode_o             <= SLEEP_MODE_RST;
      sleep_enable_o           <= SLEEP_EN_RST;
      sleep_request_o          <= SLEEP_REQ_RST;
      deep_sleep_mode_select_o <= DEEP_MODE_RST;
      deep_sleep_enable_ctl_o  <= DEEP_EN_RST;
      deep_sleep_request_ctl_o <= DEEP_REQ_RST;
    end
  end

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  property p_dvs;
    @(posedge clk_i) disable iff (sys_rst_i)
      dvs_mode_o == (buck2_code_o == CODE_0V75);
  endproperty
  a_dvs: assert property (p_dvs) else $error("dvs flag wrong");
  property p_order;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(en_w[2]) |-> good_w[1];
  endproperty
  a_order: assert property (p_order) else $error("buck2 before ldo1 good");
  property p_buck1;
    @(posedge clk_i) disable iff (sys_rst_i) $rose(en_w[3]) |-> good_w[2];
  endproperty
  a_buck1: assert property (p_buck1) else $error("buck1 early");
  property p_buck3;
    @(posedge clk_i) disable iff (sys_rst_i) $rose(en_w[4]) |-> good_w[3];
  endproperty
  a_buck3: assert property (p_buck3) else $error("buck3 early");
  property p_ldo1;
    @(posedge clk_i) disable iff (sys_rst_i) $rose(en_w[1]) |-> good_w[0];
  endproperty
  a_ldo1: assert property (p_ldo1) else $error("ldo1 early");
  property p_ldo2;
    @(posedge clk_i) disable iff (sys_rst_i) $rose(en_w[0]) |-> !uvlo_s;
  endproperty
  a_ldo2: assert property (p_ldo2) else $error("ldo2 without uvlo release");
  property p_rst;
    @(posedge clk_i) disable iff (sys_rst_i)
      !system_reset_release_out_oe_o |-> good_w[4] || $past(good_w[4]);
  endproperty
  a_rst: assert property (p_rst) else $error("reset released early");
  property p_ext;
    @(posedge clk_i) disable iff (sys_rst_i)
      !external_supply_enable_out_oe_o |-> good_w[2] || $past(good_w[2]);
  endproperty
  a_ext: assert property (p_ext) else $error("ext enable early");
  property p_b3v;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i ##1 ce_i && $stable(vsel_s) |->
        buck3_code_o == (vsel_s ? CODE_1V2 : CODE_1V8);
  endproperty
  a_b3v: assert property (p_b3v) else $error("buck3 code wrong");
  property p_b2v;
    @(posedge clk_i) disable iff (sys_rst_i)
      ce_i ##1 ce_i && $stable(lsel_s) |->
        buck2_code_o == (lsel_s ? CODE_0V9 : CODE_0V75);
  endproperty
  a_b2v: assert property (p_b2v) else $error("buck2 code wrong");
  property p_deep;
    @(posedge clk_i) disable iff (sys_rst_i)
      {sleep_mode_o, sleep_enable_o, sleep_request_o} == 3'b000 &&
      {deep_sleep_mode_select_o, deep_sleep_enable_ctl_o,
       deep_sleep_request_ctl_o} == 3'b100;
  endproperty
  a_deep: assert property (p_deep) else $error("sleep defaults wrong");
  c_all_up: cover property (@(posedge clk_i) $rose(good_w[4]));
  c_rst_rel: cover property (@(posedge clk_i) $fell(system_reset_release_out_oe_o));
  c_dvs: cover property (@(posedge clk_i) $rose(dvs_mode_o));
endmodule // pps_sequencer
`default_nettype wire

// [tb/pps_host_model.sv]
// Purpose: board and host side of the sequencer pins
// Assumes: open-drain lines carry pull-ups to the host supply
// Notes:   the voltage strap is latched only while reset is held
`timescale 1ns/10ps
`default_nettype none
module pps_host_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // board strap
  input  wire logic strap_level_i,
  output logic      voltage_select_input_o,
  // open-drain pins
  input  wire logic rst_out_i,
  input  wire logic rst_oe_i,
  input  wire logic ext_out_i,
  input  wire logic ext_oe_i,
  output logic      reset_line_o,
  output logic      ext_line_o
);
  initial voltage_select_input_o = 1'b1;

  // a fitted resistor cannot move in service, so follow it only in reset
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      voltage_select_input_o <= strap_level_i;
  end

  assign reset_line_o = rst_oe_i ? rst_out_i : 1'b1;
  assign ext_line_o   = ext_oe_i ? ext_out_i : 1'b1;
endmodule // pps_host_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the power sequencer
// Assumes: 20 MHz clock, short reset and enable delays
// Notes:   one full power-up, timings checked to within 3 cycles
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pps_pkg::*;
  localparam int RST_N = 20;
  localparam int EXT_N = 10;
  logic        clk_i, sys_rst_i, uvlo, lvl, strap, vsel, match, rd, ce;
  logic        rst_o, rst_oe, ext_o, ext_oe, rst_line, ext_line, dvs;
  logic        s_mode, s_en, s_req, d_mode, d_en, d_req;
  logic [7:0]  addr, b1, b2, b3, ldo;
  logic [4:0]  en, good;
  logic [15:0] b2_mv, ldo_mv;
  int          n_mismatch, n_tests, cyc, t0, t_rst, t_ext;
  int          t_en[5];
  int          t_good[5];
  logic [7:0]  abytes[7] = '{8'h4A, 8'h4B, 8'h48, 8'h4C, 8'h25, 8'hCA, 8'h4E};

  pps_sequencer #(.RST_CYC(RST_N), .EXT_CYC(EXT_N)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .input_undervoltage_lockout_i(uvlo), .voltage_select_input_i(vsel),
    .level_select_input_i(lvl), .addr_byte_i(addr),
    .addr_match_o(match), .addr_read_o(rd),
    .system_reset_release_out_o(rst_o),
    .system_reset_release_out_oe_o(rst_oe),
    .external_supply_enable_out_o(ext_o),
    .external_supply_enable_out_oe_o(ext_oe),
    .rail_enable_o(en), .rail_good_o(good), .buck1_code_o(b1),
    .buck2_code_o(b2), .buck3_code_o(b3), .ldo_voltage_code_o(ldo),
    .buck2_mv10_o(b2_mv), .ldo_mv10_o(ldo_mv), .dvs_mode_o(dvs),
    .sleep_mode_o(s_mode), .sleep_enable_o(s_en), .sleep_request_o(s_req),
    .deep_sleep_mode_select_o(d_mode), .deep_sleep_enable_ctl_o(d_en),
    .deep_sleep_request_ctl_o(d_req));

  pps_host_model host_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .strap_level_i(strap),
    .voltage_select_input_o(vsel), .rst_out_i(rst_o), .rst_oe_i(rst_oe),
    .ext_out_i(ext_o), .ext_oe_i(ext_oe), .reset_line_o(rst_line),
    .ext_line_o(ext_line));

  // --------------------------------------------------------------------
  // clock, timeout and edge recorder
  // --------------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // full power-up is about 77000 cycles
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc >= 90000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  always @(negedge clk_i)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (en[i] === 1'b1 && t_en[i] < 0) t_en[i] = cyc;
      if (good[i] === 1'b1 && t_good[i] < 0) t_good[i] = cyc;
    end
    if (rst_line === 1'b1 && t_rst < 0) t_rst = cyc;
    if (ext_line === 1'b1 && t_ext < 0) t_ext = cyc;
  end

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic check_val(input string name, input logic [15:0] exp,
                           input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_cnt(input string name, input int exp, input int got);
    n_tests++;
    if (got < exp - 3 || got > exp + 3)
    begin
      n_mismatch++;
      $display("FAIL %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic apply_reset(input logic level);
    @(negedge clk_i);
    strap = level;
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    for (int i = 0; i < 5; i++)
    begin
      t_en[i] = -1;
      t_good[i] = -1;
    end
    t_rst = -1;
    t_ext = -1;
  endtask

  task automatic set_level(input logic v);
    @(negedge clk_i);
    lvl = v;
    repeat (6) @(negedge clk_i);
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial
  begin
    sys_rst_i = 1'b1;
    ce = 1'b1;
    uvlo = 1'b1;
    lvl = 1'b1;
    strap = 1'b0;
    addr = 8'h00;
    cyc = 0;
    apply_reset(1'b0);
    check_val("rails_held", 16'h0000, {11'h000, en});
    check_val("rst_line", 16'h0000, {15'h0000, rst_line});
    check_val("ext_line", 16'h0000, {15'h0000, ext_line});
    check_val("buck3_low", {8'h00, CODE_1V8}, {8'h00, b3});
    check_val("buck1_code", {8'h00, CODE_3V3}, {8'h00, b1});
    check_val("ldo_code", {8'h00, CODE_1V8}, {8'h00, ldo});
    check_val("ldo_mv", 16'(8000 + 125 * 8'h50), ldo_mv);
    check_val("sleep", 16'h0000, {13'h0000, s_mode, s_en, s_req});
    check_val("deep", 16'h0004, {13'h0000, d_mode, d_en, d_req});
    foreach (abytes[k])
    begin
      @(negedge clk_i);
      addr = abytes[k];
      #1;
      check_val("addr", {14'h0000, abytes[k][7:1] == 7'h25,
                abytes[k] == 8'h4B}, {14'h0000, match, rd});
    end
    @(negedge clk_i);
    ce = 1'b0;
    set_level(1'b0);
    check_val("ce_freeze", {8'h00, CODE_0V9}, {8'h00, b2});
    ce = 1'b1;
    set_level(1'b0);
    check_val("buck2_dvs", {7'h00, 1'b1, CODE_0V75}, {7'h00, dvs, b2});
    check_val("buck2_mv_dvs", 16'd7500, b2_mv);
    check_val("others_fixed", 16'hC850, {b1, b3});
    check_val("ldo_fixed", {8'h00, CODE_1V8}, {8'h00, ldo});
    set_level(1'b1);
    check_val("buck2_pri", {7'h00, 1'b0, CODE_0V9}, {7'h00, dvs, b2});
    check_val("buck2_mv_pri", 16'd9000, b2_mv);
    apply_reset(1'b1);
    check_val("buck3_high", {8'h00, CODE_1V2}, {8'h00, b3});
    t0 = cyc;
    uvlo = 1'b0;
    while (t_rst < 0) @(negedge clk_i);
    check_cnt("ldo2_start", 3, t_en[0] - t0);
    check_cnt("ldo2_ss", LDO_SS_CYC, t_good[0] - t_en[0]);
    check_cnt("ldo1_start", 1, t_en[1] - t_good[0]);
    check_cnt("ldo1_ss", LDO_SS_CYC, t_good[1] - t_en[1]);
    check_cnt("buck2_start", BUCK_START_CYC, t_en[2] - t_good[1]);
    check_cnt("buck2_ss", BUCK_SS_CYC, t_good[2] - t_en[2]);
    check_cnt("buck1_start", BUCK_START_CYC, t_en[3] - t_good[2]);
    check_cnt("buck1_ss", BUCK_SS_CYC, t_good[3] - t_en[3]);
    check_cnt("buck3_start", BUCK_START_CYC, t_en[4] - t_good[3]);
    check_cnt("buck3_ss", BUCK_SS_CYC, t_good[4] - t_en[4]);
    check_cnt("ext_delay", EXT_N, t_ext - t_good[2]);
    check_cnt("rst_delay", RST_N, t_rst - t_good[4]);
    uvlo = 1'b1;
    repeat (100) @(negedge clk_i);
    check_val("off_delay", 16'h001F, {11'h000, en});
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
